/* File: src/port_cfg_pkg.sv */
/*
 Constants for the port direction and pin option block: register offsets,
 field positions, reset values and mode codes.
 Assumes an 8-bit register port with byte addresses as printed.
*/
package port_cfg_pkg;
   localparam logic [7:0] port0_direction_addr = 8'h93;
   localparam logic [7:0] port1_direction_addr = 8'h94;
   localparam logic [7:0] port2_direction_addr = 8'h95;
   localparam logic [7:0] port3_direction_addr = 8'h96;
   localparam logic [7:0] port0_option_addr = 8'h9e;
   localparam logic [7:0] port1_option_addr = 8'h9f;
   localparam logic [7:0] port2_option_addr = 8'ha0;
   localparam logic [7:0] port3_option_addr = 8'ha1;
   localparam logic [7:0] direction_reset = 8'hff;
   localparam logic [7:0] option_reset = 8'h00;
   localparam logic [2:0] mode_reset = 3'h0;
   localparam int mode_msb = 7;
   localparam int mode_lsb = 5;
   localparam int in_out_bit = 4;
   localparam int latch_bit = 3;
   localparam int index_msb = 2;
   localparam logic [2:0] out_normal = 3'h0;
   localparam logic [2:0] out_high = 3'h3;
   localparam int max_ports = 4;
   localparam int port3_pins = 7;
endpackage

/* File: src/pin_option_port.sv */
/*
 Option storage for one 8-bit port: per-pin input and output mode codes,
 the latched read selection and the read-back code.
 Assumes one-cycle write strobes from the register decoder on the same clock.
*/
module pin_option_port #(
   parameter int pin_count = 8
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Write side
   input wire logic wr,
   input wire logic [7:0] wdata,
   // Read-back and per-pin state
   output logic [2:0] read_mode,
   output logic [3*8-1:0] out_mode,
   output logic [3*8-1:0] in_mode
);
   initial begin
      if (pin_count < 1 || pin_count > 8) $error("pin_count out of range");
   end

   logic [3*8-1:0] out_q, out_d, in_q, in_d;
   logic [2:0] sel_q, sel_d;
   logic dir_q, dir_d;
   logic [2:0] idx;
   logic [2:0] code;

   assign idx = wdata[port_cfg_pkg::index_msb:0];
   assign code = wdata[port_cfg_pkg::mode_msb:port_cfg_pkg::mode_lsb];

   always_comb begin
      out_d = out_q;
      in_d = in_q;
      sel_d = sel_q;
      dir_d = dir_q;
      if (wr) begin
         if (wdata[port_cfg_pkg::latch_bit]) begin
            // Latching write keeps the mode field out of the pins
            sel_d = idx;
            dir_d = wdata[port_cfg_pkg::in_out_bit];
         end else if (int'(idx) < pin_count) begin
            // One pin per write; illegal output codes are dropped
            if (wdata[port_cfg_pkg::in_out_bit]) begin
               in_d[3*idx +: 3] = code;
            end else if (code == port_cfg_pkg::out_normal || code == port_cfg_pkg::out_high) begin
               out_d[3*idx +: 3] = code;
            end
         end
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         out_q <= '0;
         in_q <= '0;
         sel_q <= 3'h0;
         dir_q <= 1'b0;
      end else begin
         out_q <= out_d;
         in_q <= in_d;
         sel_q <= sel_d;
         dir_q <= dir_d;
      end
   end

   // Read-back follows the latched selection
   assign read_mode = dir_q ? in_q[3*sel_q +: 3] : out_q[3*sel_q +: 3];
   assign out_mode = out_q;
   assign in_mode = in_q;

   latched_out_a: assert property (@(posedge clk) disable iff (!rst_n)
      wr && wdata[port_cfg_pkg::latch_bit] && !wdata[port_cfg_pkg::in_out_bit]
      |=> read_mode == out_q[3*$past(idx) +: 3]) else $error("latched read wrong");
   latch_keeps_a: assert property (@(posedge clk) disable iff (!rst_n)
      wr && wdata[port_cfg_pkg::latch_bit] |=> out_q == $past(out_q) && in_q == $past(in_q))
      else $error("latch write changed modes");
   legal_out_a: assert property (@(posedge clk) disable iff (!rst_n)
      out_q[2:0] == port_cfg_pkg::out_normal || out_q[2:0] == port_cfg_pkg::out_high)
      else $error("illegal output code stored");
   cover_latch_c: cover property (@(posedge clk) wr && wdata[port_cfg_pkg::latch_bit]);
endmodule

/* File: src/port_direction_and_pin_options.sv */
/*
 Port direction registers and indirect pin option registers for up to four
 8-bit general-purpose ports, reached over a plain register port.
 Assumes one-cycle strobes from the microcontroller on clk; read data stands
 in the cycle after the read strobe.
*/
module port_direction_and_pin_options #(
   parameter int port_count = 4,
   parameter bit port0_pin7 = 1'b1
) (
   // Clock and reset
   input wire logic clk,
   input wire logic reset_n,
   // Register port
   input wire logic [7:0] addr,
   input wire logic [7:0] wdata,
   input wire logic wr_en,
   input wire logic rd_en,
   output logic [7:0] rdata,
   // Pin control, 8 bits per port for drive and routing, 24 bits (3 per pin) per port for modes
   output logic [31:0] pin_out_en,
   output logic [31:0] pin_to_mcu,
   output logic [95:0] pin_out_mode,
   output logic [95:0] pin_in_mode
);
   initial begin
      if (port_count < 1 || port_count > port_cfg_pkg::max_ports) $error("port_count out of range");
   end

   ////////////////////////////////////////////////////////////////////////////
   // Reset release

   logic rst_meta_q, rst_n_q;
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         rst_meta_q <= 1'b0;
         rst_n_q <= 1'b0;
      end else begin
         rst_meta_q <= 1'b1;
         rst_n_q <= rst_meta_q;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Direction registers

   localparam logic [7:0] dir_addr [4] = '{port_cfg_pkg::port0_direction_addr,
      port_cfg_pkg::port1_direction_addr, port_cfg_pkg::port2_direction_addr,
      port_cfg_pkg::port3_direction_addr};
   localparam logic [7:0] opt_addr [4] = '{port_cfg_pkg::port0_option_addr,
      port_cfg_pkg::port1_option_addr, port_cfg_pkg::port2_option_addr,
      port_cfg_pkg::port3_option_addr};

   logic [7:0] dir_q [4];
   logic [7:0] dir_d [4];
   logic [7:0] impl_mask [4];
   logic [2:0] opt_read [4];
   logic [23:0] opt_out [4];
   logic [23:0] opt_in [4];
   logic [7:0] rdata_d;
   logic [31:0] out_en_d;

   genvar g;
   generate
      for (g = 0; g < 4; g++) begin : gen_port
         // Absent ports and pins stay inputs and read as zero
         if (g >= port_count) begin : gen_none
            assign impl_mask[g] = 8'h00;
            assign opt_read[g] = 3'h0;
            assign opt_out[g] = '0;
            assign opt_in[g] = '0;
         end else begin : gen_port_on
            if (g == 0) begin : gen_p0
               assign impl_mask[g] = port0_pin7 ? 8'hff : 8'h7f;
            end else if (g == 3) begin : gen_p3
               assign impl_mask[g] = 8'h7f;
            end else begin : gen_full
               assign impl_mask[g] = 8'hff;
            end
            pin_option_port #(
               .pin_count((g == 3 || (g == 0 && !port0_pin7)) ? 7 : 8)
            ) u_opt (
               .clk(clk),
               .rst_n(rst_n_q),
               .wr(wr_en && addr == opt_addr[g]),
               .wdata(wdata),
               .read_mode(opt_read[g]),
               .out_mode(opt_out[g]),
               .in_mode(opt_in[g])
            );
         end
         always_comb begin
            dir_d[g] = dir_q[g];
            if (wr_en && addr == dir_addr[g]) begin
               // Absent bits held at input
               dir_d[g] = (wdata & impl_mask[g]) | ~impl_mask[g];
            end
         end
         always_ff @(posedge clk or negedge rst_n_q) begin
            if (!rst_n_q) begin
               dir_q[g] <= port_cfg_pkg::direction_reset;
            end else begin
               dir_q[g] <= dir_d[g];
            end
         end
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////
   // Read path and pin outputs

   always_comb begin
      rdata_d = 8'h00;
      for (int i = 0; i < 4; i++) begin
         if (addr == dir_addr[i]) begin
            rdata_d = dir_q[i] & impl_mask[i];
         end
         if (addr == opt_addr[i]) begin
            rdata_d = {opt_read[i], 5'h00};
         end
      end
      if (!rd_en) begin
         rdata_d = 8'h00;
      end
      for (int i = 0; i < 4; i++) begin
         out_en_d[8*i +: 8] = ~dir_q[i];
      end
   end

   always_ff @(posedge clk or negedge rst_n_q) begin
      if (!rst_n_q) begin
         rdata <= 8'h00;
         pin_out_en <= '0;
         pin_to_mcu <= '1;
         pin_out_mode <= '0;
         pin_in_mode <= '0;
      end else begin
         rdata <= rdata_d;
         pin_out_en <= out_en_d;
         pin_to_mcu <= ~out_en_d;
         pin_out_mode <= {opt_out[3], opt_out[2], opt_out[1], opt_out[0]};
         pin_in_mode <= {opt_in[3], opt_in[2], opt_in[1], opt_in[0]};
      end
   end

   dir_drive_a: assert property (@(posedge clk) disable iff (!rst_n_q)
      wr_en && addr == port_cfg_pkg::port1_direction_addr && port_count > 1
      |=> ##1 pin_out_en[15:8] == ~$past(wdata, 2)) else $error("direction not applied");
   dir_read_a: assert property (@(posedge clk) disable iff (!rst_n_q)
      rd_en && addr == port_cfg_pkg::port0_direction_addr
      |=> rdata == (dir_q[0] & impl_mask[0])) else $error("direction readback wrong");
   p3_reserved_a: assert property (@(posedge clk) disable iff (!rst_n_q)
      !pin_out_en[31]) else $error("port 3 bit 7 drives");
   absent_port_a: assert property (@(posedge clk) disable iff (!rst_n_q)
      port_count < 3 |-> pin_out_en[23:16] == 8'h00) else $error("absent port 2 drives");
   opt_read_a: assert property (@(posedge clk) disable iff (!rst_n_q)
      rd_en && addr == port_cfg_pkg::port0_option_addr |=> rdata[4:0] == 5'h00)
      else $error("option read low bits set");
   idle_read_a: assert property (@(posedge clk) disable iff (!rst_n_q)
      !rd_en |=> rdata == 8'h00) else $error("read data outside slot");
   // Pads must never be both driven and routed to the input path
   mcu_route_a: assert property (@(posedge clk) disable iff (!rst_n_q)
      pin_to_mcu == ~pin_out_en) else $error("input routing not inverse of drive");
   absent_pin_a: assert property (@(posedge clk) disable iff (!rst_n_q)
      !port0_pin7 |-> !pin_out_en[7]) else $error("absent port 0 pin 7 drives");
   single_port_a: assert property (@(posedge clk) disable iff (!rst_n_q)
      port_count == 1 |-> pin_out_en[31:8] == 24'h000000)
      else $error("absent ports drive");
   cover_dir_c: cover property (@(posedge clk) wr_en && addr == port_cfg_pkg::port0_direction_addr);
   cover_opt_c: cover property (@(posedge clk) rd_en && addr == port_cfg_pkg::port0_option_addr);
   cover_out_c: cover property (@(posedge clk) pin_out_en != 32'h0);
endmodule

/* File: test/pin_pad_model.sv */
/*
 Far-side model of the port pins: each pin is either driven by the block or
 routed to the microcontroller input path.
 Assumes the pin control buses of the block, 8 bits per port.
*/
module pin_pad_model (
   // Pin control from the block
   input wire logic [31:0] pin_out_en,
   input wire logic [31:0] pin_to_mcu,
   // Clash flag
   output logic clash
);
   timeunit 1ns;
   timeprecision 1ps;
   // A pin both driven and read, or neither, would float or fight on the pad
   assign clash = |(pin_out_en ~^ pin_to_mcu);
endmodule

/* File: test/port_direction_and_pin_options_tb.sv */
/*
 Self-checking bench for the port direction and pin option block.
 Assumes the register port timing of the block: read data one cycle late.
*/
module port_direction_and_pin_options_tb;
   timeunit 1ns;
   timeprecision 1ps;
   typedef struct packed {logic [7:0] a; logic [7:0] d; logic [7:0] e;} row_t;
   // Write then read back the same address
   localparam row_t rows [11] = '{
      '{8'h93, 8'h00, 8'h00}, '{8'h94, 8'h5a, 8'h5a}, '{8'h95, 8'ha5, 8'ha5},
      '{8'h96, 8'h80, 8'h00}, '{8'h90, 8'h55, 8'h00}, '{8'h9e, 8'h65, 8'h00},
      '{8'h9e, 8'h0d, 8'h60}, '{8'h9e, 8'h45, 8'h60}, '{8'h9e, 8'hb2, 8'h60},
      '{8'h9e, 8'h1a, 8'ha0}, '{8'h9e, 8'hed, 8'h60}};
   logic clk, reset_n, wr_en, rd_en, clash;
   logic [7:0] addr, wdata, rdata, rdata_small, d;
   logic [31:0] pin_out_en, pin_to_mcu, out_en_small;
   logic [95:0] pin_out_mode, pin_in_mode;
   int num_errors = 0;
   int checked = 0;
   int cycles = 0;

   ////////////////////////////////////////////////////////////////////////
   port_direction_and_pin_options dut_u (.clk(clk), .reset_n(reset_n), .addr(addr),
      .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .pin_out_en(pin_out_en),
      .pin_to_mcu(pin_to_mcu), .pin_out_mode(pin_out_mode), .pin_in_mode(pin_in_mode));
   // Smallest package shares the bus to see absent ports and pin
   port_direction_and_pin_options #(.port_count(1), .port0_pin7(1'b0)) small_u (
      .clk(clk), .reset_n(reset_n), .addr(addr), .wdata(wdata), .wr_en(wr_en),
      .rd_en(rd_en), .rdata(rdata_small), .pin_out_en(out_en_small), .pin_to_mcu(),
      .pin_out_mode(), .pin_in_mode());
   pin_pad_model pad_u (.pin_out_en(pin_out_en), .pin_to_mcu(pin_to_mcu), .clash(clash));

   ////////////////////////////////////////////////////////////////////////
   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         num_errors++;
         $display("MISMATCH %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic bus_wr(input logic [7:0] a, input logic [7:0] v);
      @(posedge clk);
      addr <= a;
      wdata <= v;
      wr_en <= 1'b1;
      @(posedge clk);
      wr_en <= 1'b0;
   endtask
   task automatic bus_rd(input logic [7:0] a, output logic [7:0] v);
      @(posedge clk);
      addr <= a;
      rd_en <= 1'b1;
      @(posedge clk);
      rd_en <= 1'b0;
      #1 v = rdata;
   endtask
   task automatic wrap_up;
      $display("Counts: %0d checked, %0d mismatches", checked, num_errors);
      if (num_errors == 0 && checked > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   // Whole run is under 80 cycles; the ceiling of 3000 leaves ample margin
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 3000) begin
         num_errors++;
         wrap_up();
      end
   end

   initial begin
      reset_n = 1'b0;
      addr = 8'h00;
      wdata = 8'h00;
      wr_en = 1'b0;
      rd_en = 1'b0;
      repeat (10) @(posedge clk);
      reset_n <= 1'b1;
      repeat (3) @(posedge clk);
      #1 check("out_en", pin_out_en, 32'h0);
      check("to_mcu", pin_to_mcu, 32'hffffffff);
      check("clash", clash, 1'b0);
      for (int i = 0; i < 4; i++) begin
         bus_rd(8'h93 + 8'(i), d);
         // Port 3 bit 7 is reserved, so it is not judged
         check("dir_reset", d | ((i == 3) ? 8'h80 : 8'h00), 8'hff);
         check("small_dir_reset", rdata_small, (i == 0) ? 8'h7f : 8'h00);
      end
      $display("reset test done");
      for (int i = 0; i < 11; i++) begin
         bus_wr(rows[i].a, rows[i].d);
         bus_rd(rows[i].a, d);
         check("row", d, rows[i].e);
      end
      $display("register table test done");
      repeat (2) @(posedge clk);
      #1 check("out_en", pin_out_en, 32'h7f5aa5ff);
      check("to_mcu", pin_to_mcu, 32'h80a55a00);
      check("clash", clash, 1'b0);
      check("out_mode5", pin_out_mode[17:15], 3'h3);
      check("in_mode2", pin_in_mode[8:6], 3'h5);
      check("small_out_en", out_en_small, 32'h0000007f);
      $display("pin output test done");
      @(posedge clk);
      reset_n <= 1'b0;
      repeat (2) @(posedge clk);
      #1 check("out_en", pin_out_en, 32'h0);
      @(posedge clk);
      reset_n <= 1'b1;
      repeat (3) @(posedge clk);
      bus_rd(8'h93, d);
      check("dir_reset", d, 8'hff);
      $display("second reset test done");
      wrap_up();
   end
endmodule
